/* src/ebpc_cfg.svh */
// Constants for the external bus pin control block
`ifndef EBPC_CFG_SVH
`define EBPC_CFG_SVH
`define EBPC_CS_PINS      4
`define EBPC_BUS_ACTIVE_BITS_W     5
`define EBPC_WAIT_W       4
`define EBPC_CNT_NONE     2'h2
`define EBPC_CNT_TWO      2'h1
`define EBPC_CNT_THREE    2'h0
`define EBPC_CNT_FOUR     2'h3
`define EBPC_MASK_NONE    4'h0
`define EBPC_MASK_TWO     4'h3
`define EBPC_MASK_THREE   4'h7
`define EBPC_MASK_FOUR    4'hF
`define EBPC_OD_RESET     4'h0
`define EBPC_WAIT_ZERO    4'h0
`define EBPC_WAIT_STEP    4'h1
`define EBPC_SYNC_W       6
// Hold request, ready and NMI lanes read idle in reset; strap lanes pass
`define EBPC_SYNC_IDLE    6'h2C
`define EBPC_CHK_WAITS    4'h3
`endif

/* src/ebpc_pkg.sv */
// Types shared by the external bus pin control block
package ebpc_pkg;
  typedef enum logic [1:0] {
    EBPC_ACC_INTERNAL,
    EBPC_ACC_XPERIPH,
    EBPC_ACC_EXTERNAL
  } ebpc_access_t;

  typedef enum logic {
    EBPC_WR_GENERAL,
    EBPC_WR_SPLIT
  } ebpc_wrmode_t;
endpackage : ebpc_pkg

/* src/ebpc_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
`include "ebpc_cfg.svh"
module ebpc_sync
  import ebpc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic [`EBPC_SYNC_W-1:0] asyncIn,
  output var  logic [`EBPC_SYNC_W-1:0] syncOut
);
  logic [`EBPC_SYNC_W-1:0] meta_q;

  // Straps must still flow in reset so they can be latched; others read idle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_q  <= asyncIn | `EBPC_SYNC_IDLE;
      syncOut <= meta_q | `EBPC_SYNC_IDLE;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : ebpc_sync
`default_nettype wire

/* src/ebpc_pin_control.sv */
// External bus pin control: chip selects, arbitration, strobes, ready, NMI
`timescale 1ns/1ps
`default_nettype none
`include "ebpc_cfg.svh"
module ebpc_pin_control
  import ebpc_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic [1:0]                bootConfigPort,
  output var  logic [1:0]                chipSelectCountField,
  input  wire logic [`EBPC_CS_PINS-1:0]  csSelect,
  input  wire logic [`EBPC_CS_PINS-1:0]  gpioOut,
  input  wire logic [`EBPC_CS_PINS-1:0]  gpioOe,
  input  wire logic                      odWrite,
  input  wire logic [`EBPC_CS_PINS-1:0]  odWriteData,
  output var  logic [`EBPC_CS_PINS-1:0]  portOpenDrainSelectBits,
  output logic      [`EBPC_CS_PINS-1:0]  csPinOut,
  output logic      [`EBPC_CS_PINS-1:0]  csPinOe,
  output logic      [`EBPC_CS_PINS-1:0]  csPullupEn,
  input  wire logic                      arbitrationEnableBit,
  input  wire logic                      holdReqPinIn,
  output logic                           holdReqPinOe,
  output var  logic                      holdAcknowledgeOutput,
  output logic                           holdAckOe,
  input  wire logic                      busRequestInt,
  output var  logic                      busRequestOutput,
  output logic                           busRequestOe,
  output var  logic                      holdMode,
  input  wire logic                      cycleStart,
  input  wire ebpc_access_t              cycleKind,
  input  wire logic                      cycleRead,
  input  wire logic                      cycleWrite,
  input  wire logic                      byteHigh,
  input  wire logic                      byteLow,
  input  wire logic [`EBPC_BUS_ACTIVE_BITS_W-1:0] busActiveBits,
  input  wire logic                      peripheralVisibilityBit,
  input  wire ebpc_wrmode_t              writeMode,
  output var  logic                      aleOut,
  output var  logic                      readStrobeN,
  output var  logic                      writeLowStrobeN,
  output var  logic                      writeHighStrobeN,
  output logic                           strobePullupEn,
  input  wire logic                      readyCtlEn,
  input  wire logic                      readyAsyncMode,
  input  wire logic [`EBPC_WAIT_W-1:0]   waitStates,
  input  wire logic                      readyPinN,
  output var  logic                      cycleEnd,
  input  wire logic                      externalAccessSelect,
  output var  logic                      bootFromRom,
  input  wire logic                      nmiPinN,
  output var  logic                      nmiTrap,
  output logic                           powerDownValid
);
  logic [`EBPC_SYNC_W-1:0] pinRaw;
  logic [`EBPC_SYNC_W-1:0] pinSync;
  wire  [1:0] bootSync  = pinSync[1:0];
  wire        holdSyncN = pinSync[2];
  wire        readySyncN = pinSync[3];
  wire        eaSync    = pinSync[4];
  wire        nmiSyncN  = pinSync[5];

  assign pinRaw = {nmiPinN, externalAccessSelect, readyPinN, holdReqPinIn, bootConfigPort};

  ebpc_sync u_sync (
    .clk     (clk),
    .rstn    (rstn),
    .asyncIn (pinRaw),
    .syncOut (pinSync)
  );

  function automatic logic [`EBPC_CS_PINS-1:0] csMask(input logic [1:0] code);
    case (code)
      `EBPC_CNT_NONE:  csMask = `EBPC_MASK_NONE;
      `EBPC_CNT_TWO:   csMask = `EBPC_MASK_TWO;
      `EBPC_CNT_THREE: csMask = `EBPC_MASK_THREE;
      default:         csMask = `EBPC_MASK_FOUR;
    endcase
  endfunction : csMask

  // Straps follow the pins during reset and freeze at release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      chipSelectCountField <= bootSync;
      bootFromRom          <= eaSync;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      portOpenDrainSelectBits <= `EBPC_OD_RESET;
    end else if (odWrite) begin
      portOpenDrainSelectBits <= odWriteData;
    end
  end

  // Chip-select pins
  logic holdMode_q;
  wire  [`EBPC_CS_PINS-1:0] csUsed = csMask(chipSelectCountField);
  wire  holdEntry  = holdMode & !holdMode_q;
  wire  holdReqNow = arbitrationEnableBit & !holdSyncN;
  wire  [`EBPC_CS_PINS-1:0] csPushOe = ~portOpenDrainSelectBits | csSelect;
  wire  [`EBPC_CS_PINS-1:0] csDrvOe  = holdEntry ? {`EBPC_CS_PINS{1'b1}}
                                     : (holdMode ? {`EBPC_CS_PINS{1'b0}} : csPushOe);

  // Open-drain drives only the low level, except high for the one hold-entry cycle; push/pull drives both
  assign csPinOut = (csUsed & (holdEntry ? {`EBPC_CS_PINS{1'b1}} : ~csSelect))
                  | (~csUsed & gpioOut);
  assign csPinOe  = (csUsed & csDrvOe) | (~csUsed & gpioOe);
  wire  [`EBPC_CS_PINS-1:0] csPullHold = {`EBPC_CS_PINS{holdMode}} & csUsed;
  assign csPullupEn = {`EBPC_CS_PINS{!rstn}}
                    | (csPullHold & ~portOpenDrainSelectBits);

  // Arbitration pins
  assign holdReqPinOe = 1'b0;
  assign holdAckOe    = arbitrationEnableBit;
  assign busRequestOe = arbitrationEnableBit;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      holdMode              <= 1'b0;
      holdMode_q            <= 1'b0;
      holdAcknowledgeOutput <= 1'b1;
      busRequestOutput      <= 1'b1;
    end else begin
      holdMode              <= holdReqNow;
      holdMode_q            <= holdMode;
      holdAcknowledgeOutput <= !holdReqNow;
      busRequestOutput      <= !(arbitrationEnableBit & busRequestInt);
    end
  end

  // Strobes
  wire busOn     = |busActiveBits;
  wire isExt     = cycleKind == EBPC_ACC_EXTERNAL;
  wire isXper    = cycleKind == EBPC_ACC_XPERIPH;
  wire aleD      = cycleStart & (isExt | (isXper & busOn));
  wire strobeVis = isExt | (isXper & busOn & peripheralVisibilityBit);
  wire strobeOff = holdMode;
  wire rdD       = cycleStart & cycleRead & strobeVis & !strobeOff;
  wire wrAny     = cycleStart & cycleWrite & strobeVis & !strobeOff;
  wire wrLowD    = wrAny & ((writeMode == EBPC_WR_GENERAL) | byteLow);
  wire wrHighD   = wrAny & (writeMode == EBPC_WR_SPLIT) & byteHigh;

  assign strobePullupEn = !rstn | holdMode;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aleOut           <= 1'b0;
      readStrobeN      <= 1'b1;
      writeLowStrobeN  <= 1'b1;
      writeHighStrobeN <= 1'b1;
    end else begin
      aleOut           <= aleD;
      readStrobeN      <= !rdD;
      writeLowStrobeN  <= !wrLowD;
      writeHighStrobeN <= !wrHighD;
    end
  end

  // Ready and waitstates
  // Async mode trades one cycle of latency for an extra settling stage
  logic                    inCycle_q;
  logic [`EBPC_WAIT_W-1:0] waitCnt_q;
  logic                    readyLate_q;
  wire  readyN    = readyAsyncMode ? readyLate_q : readySyncN;
  wire  waitsDone = waitCnt_q == `EBPC_WAIT_ZERO;
  wire  endNow    = inCycle_q & waitsDone & (!readyCtlEn | !readyN);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      inCycle_q   <= 1'b0;
      waitCnt_q   <= `EBPC_WAIT_ZERO;
      readyLate_q <= 1'b1;
      cycleEnd    <= 1'b0;
    end else begin
      readyLate_q <= readySyncN;
      cycleEnd    <= endNow;
      if (cycleStart & !inCycle_q) begin
        inCycle_q <= 1'b1;
        waitCnt_q <= waitStates;
      end else if (endNow) begin
        inCycle_q <= 1'b0;
      end else if (inCycle_q & !waitsDone) begin
        waitCnt_q <= waitCnt_q - `EBPC_WAIT_STEP;
      end
    end
  end

  // NMI edge detect on the synchronised level
  logic nmiPrevN_q;
  assign powerDownValid = !nmiSyncN;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      nmiPrevN_q <= 1'b1;
      nmiTrap    <= 1'b0;
    end else begin
      nmiPrevN_q <= nmiSyncN;
      nmiTrap    <= nmiPrevN_q & !nmiSyncN;
    end
  end

  // Checks
  sequence holdRise;
    !holdMode ##1 holdMode;
  endsequence

  sequence csReleased;
    !holdMode || ((csPinOe & csUsed) == `EBPC_MASK_NONE);
  endsequence

  sequence readyPending;
    inCycle_q && readyCtlEn && readyN;
  endsequence

  chk_cs_pullup_reset: assert property (@(posedge clk) !rstn |-> csPullupEn == `EBPC_MASK_FOUR)
    else $error("chip-select pullups off in reset");
  chk_hold_drive_high: assert property (@(posedge clk) disable iff (!rstn)
    holdRise |-> (((csPinOe & csUsed) == csUsed) && ((csPinOut & csUsed) == csUsed))
      ##1 csReleased)
    else $error("chip selects not driven high once on hold entry");
  chk_od_no_pullup: assert property (@(posedge clk) disable iff (!rstn)
    (csPullupEn & portOpenDrainSelectBits) == `EBPC_MASK_NONE)
    else $error("pullup on in open-drain mode");
  chk_pullup_cond: assert property (@(posedge clk) disable iff (!rstn)
    !holdMode |-> csPullupEn == `EBPC_MASK_NONE)
    else $error("pullup on outside hold");
  chk_ale_internal: assert property (@(posedge clk) disable iff (!rstn)
    cycleStart && (cycleKind == EBPC_ACC_INTERNAL || (isXper && !busOn)) |=> !aleOut)
    else $error("address strobe on internal access");
  chk_ale_external: assert property (@(posedge clk) disable iff (!rstn)
    cycleStart && isExt |=> aleOut ##1 !aleOut || $past(cycleStart))
    else $error("address strobe missing on external cycle");
  chk_rd_hold_idle: assert property (@(posedge clk) disable iff (!rstn)
    holdMode [*2] |-> readStrobeN && writeLowStrobeN && writeHighStrobeN)
    else $error("strobe active in hold");
  chk_wait_ignore: assert property (@(posedge clk) disable iff (!rstn)
    cycleStart && !inCycle_q && waitStates == `EBPC_CHK_WAITS |=> !cycleEnd [*4])
    else $error("cycle ended inside waitstates");
  chk_nmi_trap: assert property (@(posedge clk) disable iff (!rstn)
    $fell(nmiSyncN) |=> nmiTrap ##1 !nmiTrap)
    else $error("nmi transition not trapped");
  chk_arb_dirs: assert property (@(posedge clk)
    arbitrationEnableBit |-> holdAckOe && busRequestOe && !holdReqPinOe)
    else $error("arbitration pin directions wrong");

  // Directions, straps, handshakes and pulse contents
  chk_arb_off: assert property (@(posedge clk)
    !arbitrationEnableBit |-> !holdAckOe && !busRequestOe && !holdReqPinOe)
    else $error("arbitration drivers on while disabled");
  chk_hold_ack: assert property (@(posedge clk) disable iff (!rstn)
    holdMode |-> !holdAcknowledgeOutput)
    else $error("hold without acknowledge");
  chk_straps_frozen: assert property (@(posedge clk) disable iff (!rstn)
    $past(rstn) |-> $stable(chipSelectCountField) && $stable(bootFromRom))
    else $error("strap value changed after reset");
  chk_od_reset: assert property (@(posedge clk)
    !rstn |=> portOpenDrainSelectBits == `EBPC_OD_RESET)
    else $error("open-drain bits not cleared by reset");
  chk_ale_xper: assert property (@(posedge clk) disable iff (!rstn)
    cycleStart && isXper && busOn |=> aleOut)
    else $error("address strobe missing on peripheral access");
  chk_vis_idle: assert property (@(posedge clk) disable iff (!rstn)
    cycleStart && isXper && !peripheralVisibilityBit
      |=> readStrobeN && writeLowStrobeN && writeHighStrobeN)
    else $error("strobe toggled on hidden peripheral access");
  chk_wr_split: assert property (@(posedge clk) disable iff (!rstn)
    cycleStart && cycleWrite && isExt && !holdMode && writeMode == EBPC_WR_SPLIT
      |=> writeLowStrobeN == !$past(byteLow) && writeHighStrobeN == !$past(byteHigh))
    else $error("byte write strobes do not follow byte enables");
  chk_ready_wait: assert property (@(posedge clk) disable iff (!rstn)
    readyPending |=> !cycleEnd)
    else $error("ready-controlled cycle ended without ready");
  chk_ready_free: assert property (@(posedge clk) disable iff (!rstn)
    inCycle_q && waitsDone && !readyCtlEn |=> cycleEnd)
    else $error("cycle without ready control did not end");
  chk_nmi_source: assert property (@(posedge clk) disable iff (!rstn)
    nmiTrap |-> $past(nmiSyncN, 2) && !$past(nmiSyncN))
    else $error("trap without a falling nmi");
  chk_pullup_on: assert property (@(posedge clk) disable iff (!rstn)
    holdMode |-> csPullupEn == (csUsed & ~portOpenDrainSelectBits))
    else $error("hold pullups wrong");
endmodule : ebpc_pin_control
`default_nettype wire

/* tb/ebpc_far_side.sv */
// Far-side model: slow memory answering ready and an alternate bus master
`timescale 1ns/1ps
`default_nettype none
module ebpc_far_side (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       wantHold,
  input  wire logic [3:0] readyWait,
  input  wire logic       cycleStart,
  input  wire logic       cycleEnd,
  output var  logic       holdReqPinIn,
  output var  logic       readyPinN
);
  logic [3:0] waitCnt_q;
  logic       busy_q;

  // Ready comes only readyWait edges after the cycle starts, never sooner
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_q    <= 1'h0;
      waitCnt_q <= 4'h0;
    end else if (cycleStart && !busy_q) begin
      busy_q    <= 1'h1;
      waitCnt_q <= readyWait;
    end else if (cycleEnd) begin
      busy_q <= 1'h0;
    end else if (waitCnt_q != 4'h0) begin
      waitCnt_q <= waitCnt_q - 4'h1;
    end
  end

  assign readyPinN    = !(busy_q && waitCnt_q == 4'h0);
  assign holdReqPinIn = !wantHold;
endmodule : ebpc_far_side
`default_nettype wire

/* tb/ebpc_pin_control_tb.sv */
// Self-checking bench for the external bus pin control block
`timescale 1ns/1ps
`default_nettype none
module ebpc_pin_control_tb import ebpc_pkg::*;;
  logic         clk, rstn, odWrite, arbitrationEnableBit, holdReqPinIn, busRequestInt;
  logic         cycleStart, cycleRead, cycleWrite, byteHigh, byteLow, readyPinN;
  logic         peripheralVisibilityBit, readyCtlEn, readyAsyncMode, externalAccessSelect;
  logic         nmiPinN, wantHold, holdReqPinOe, holdAcknowledgeOutput, holdAckOe;
  logic         busRequestOutput, busRequestOe, holdMode, aleOut, readStrobeN;
  logic         writeLowStrobeN, writeHighStrobeN, strobePullupEn, cycleEnd, bootFromRom;
  logic         nmiTrap, powerDownValid;
  logic [1:0]   bootConfigPort, chipSelectCountField;
  logic [3:0]   csSelect, gpioOut, gpioOe, odWriteData, portOpenDrainSelectBits, csPinOut;
  logic [3:0]   csPinOe, csPullupEn, waitStates, readyWait;
  logic [4:0]   busActiveBits;
  ebpc_access_t cycleKind;
  ebpc_wrmode_t writeMode;
  int           badCount, cmpCount;

  ebpc_pin_control dut (.clk(clk), .rstn(rstn), .bootConfigPort(bootConfigPort),
    .chipSelectCountField(chipSelectCountField), .csSelect(csSelect), .gpioOut(gpioOut),
    .gpioOe(gpioOe), .odWrite(odWrite), .odWriteData(odWriteData),
    .portOpenDrainSelectBits(portOpenDrainSelectBits), .csPinOut(csPinOut),
    .csPinOe(csPinOe), .csPullupEn(csPullupEn), .arbitrationEnableBit(arbitrationEnableBit),
    .holdReqPinIn(holdReqPinIn), .holdReqPinOe(holdReqPinOe), .holdAckOe(holdAckOe),
    .holdAcknowledgeOutput(holdAcknowledgeOutput), .busRequestInt(busRequestInt),
    .busRequestOutput(busRequestOutput), .busRequestOe(busRequestOe), .holdMode(holdMode),
    .cycleStart(cycleStart), .cycleKind(cycleKind), .cycleRead(cycleRead),
    .cycleWrite(cycleWrite), .byteHigh(byteHigh), .byteLow(byteLow),
    .busActiveBits(busActiveBits), .peripheralVisibilityBit(peripheralVisibilityBit),
    .writeMode(writeMode), .aleOut(aleOut), .readStrobeN(readStrobeN),
    .writeLowStrobeN(writeLowStrobeN), .writeHighStrobeN(writeHighStrobeN),
    .strobePullupEn(strobePullupEn), .readyCtlEn(readyCtlEn), .readyAsyncMode(readyAsyncMode),
    .waitStates(waitStates), .readyPinN(readyPinN), .cycleEnd(cycleEnd),
    .externalAccessSelect(externalAccessSelect), .bootFromRom(bootFromRom),
    .nmiPinN(nmiPinN), .nmiTrap(nmiTrap), .powerDownValid(powerDownValid));

  ebpc_far_side farSide (.clk(clk), .rstn(rstn), .wantHold(wantHold), .readyWait(readyWait),
    .cycleStart(cycleStart), .cycleEnd(cycleEnd), .holdReqPinIn(holdReqPinIn),
    .readyPinN(readyPinN));

  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string msg);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic stopTest();
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stopTest

  // Straps need three low edges to cross the synchroniser and be captured
  task automatic tskStraps();
    logic [1:0] code;
    logic [3:0] mask;
    for (int i = 0; i < 4; i++) begin
      code = 2'(i + 2);
      @(posedge clk);
      rstn <= 1'h0;
      bootConfigPort <= code;
      externalAccessSelect <= code[0];
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(csPullupEn, 4'hF, "chip-select pullups in reset");
      chk({strobePullupEn, readStrobeN, writeLowStrobeN}, 4'h7, "strobes in reset");
      chk(portOpenDrainSelectBits, 4'h0, "open-drain bits in reset");
      @(posedge clk);
      rstn <= 1'h1;
      @(negedge clk);
      chk(chipSelectCountField, code, "chip-select count");
      chk(bootFromRom, code[0], "boot source");
      mask = (code == 2'h2) ? 4'h0 : (code == 2'h3) ? 4'hF : (code == 2'h0) ? 4'h7 : 4'h3;
      chk(csPinOe, mask, "chip-select pins after reset");
    end
  endtask : tskStraps

  // Count code 01 leaves two chip selects; pins 2 and 3 stay general purpose
  task automatic tskPins();
    @(posedge clk);
    csSelect <= 4'h1;
    gpioOe <= 4'h4;
    gpioOut <= 4'hC;
    @(negedge clk);
    chk(csPinOe, 4'h7, "pin drivers");
    chk(csPinOut & csPinOe, 4'h6, "pin levels");
    chk(csPullupEn, 4'h0, "no pullup outside hold");
  endtask : tskPins

  task automatic tskCyc(input ebpc_access_t k, input logic [3:0] ctl, input logic [4:0] act,
                        input logic vis, input ebpc_wrmode_t m, input logic [3:0] exp);
    @(posedge clk);
    {cycleRead, cycleWrite, byteHigh, byteLow} <= ctl;
    cycleKind <= k;
    busActiveBits <= act;
    peripheralVisibilityBit <= vis;
    writeMode <= m;
    cycleStart <= 1'h1;
    @(posedge clk);
    cycleStart <= 1'h0;
    @(negedge clk);
    chk({aleOut, readStrobeN, writeLowStrobeN, writeHighStrobeN}, exp, "strobe set");
    repeat (3) @(posedge clk);
  endtask : tskCyc

  task automatic tskStrobes();
    tskCyc(EBPC_ACC_EXTERNAL, 4'h8, 5'h10, 1'h0, EBPC_WR_GENERAL, 4'hB);
    tskCyc(EBPC_ACC_EXTERNAL, 4'h6, 5'h10, 1'h0, EBPC_WR_GENERAL, 4'hD);
    tskCyc(EBPC_ACC_EXTERNAL, 4'h6, 5'h10, 1'h0, EBPC_WR_SPLIT, 4'hE);
    tskCyc(EBPC_ACC_EXTERNAL, 4'h5, 5'h10, 1'h0, EBPC_WR_SPLIT, 4'hD);
    tskCyc(EBPC_ACC_XPERIPH, 4'h8, 5'h00, 1'h1, EBPC_WR_GENERAL, 4'h7);
    tskCyc(EBPC_ACC_XPERIPH, 4'h8, 5'h10, 1'h0, EBPC_WR_GENERAL, 4'hF);
    tskCyc(EBPC_ACC_XPERIPH, 4'h8, 5'h01, 1'h1, EBPC_WR_GENERAL, 4'hB);
    tskCyc(EBPC_ACC_INTERNAL, 4'h8, 5'h10, 1'h1, EBPC_WR_GENERAL, 4'h7);
  endtask : tskStrobes

  task automatic tskEnd(input logic [3:0] w, input logic ctl, input logic asy,
                        input logic [3:0] rw, input int lo, input int hi);
    int n;
    @(posedge clk);
    waitStates <= w;
    readyCtlEn <= ctl;
    readyAsyncMode <= asy;
    readyWait <= rw;
    cycleKind <= EBPC_ACC_INTERNAL;
    cycleStart <= 1'h1;
    @(posedge clk);
    cycleStart <= 1'h0;
    n = 1;
    @(negedge clk);
    while (cycleEnd !== 1'h1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    chk(4'(n >= lo && n <= hi), 4'h1, "cycle end timing");
    repeat (2) @(posedge clk);
  endtask : tskEnd

  task automatic tskReady();
    tskEnd(4'h0, 1'h0, 1'h0, 4'h0, 2, 2);
    tskEnd(4'h3, 1'h0, 1'h0, 4'h0, 5, 5);
    tskEnd(4'h3, 1'h1, 1'h0, 4'h0, 5, 9);
    tskEnd(4'h1, 1'h1, 1'h0, 4'h8, 10, 15);
    tskEnd(4'h1, 1'h1, 1'h1, 4'h8, 11, 16);
  endtask : tskReady

  task automatic tskHold();
    int n;
    chk({holdAckOe, busRequestOe, holdReqPinOe}, 4'h0, "arbitration off");
    @(posedge clk);
    odWrite <= 1'h1;
    odWriteData <= 4'h2;
    arbitrationEnableBit <= 1'h1;
    busRequestInt <= 1'h1;
    @(posedge clk);
    odWrite <= 1'h0;
    wantHold <= 1'h1;
    @(negedge clk);
    chk(portOpenDrainSelectBits, 4'h2, "open-drain write");
    chk({holdAckOe, busRequestOe, holdReqPinOe}, 4'h6, "arbitration on");
    chk({busRequestOutput, holdAcknowledgeOutput}, 4'h1, "bus request, no hold yet");
    n = 0;
    while (holdMode !== 1'h1 && n < 10) begin
      n++;
      @(negedge clk);
    end
    chk({holdAcknowledgeOutput, 3'(n < 10)}, 4'h1, "hold granted");
    chk({csPinOe[1:0], csPinOut[1:0]}, 4'hF, "chip selects driven high");
    @(negedge clk);
    chk(csPinOe & 4'h3, 4'h0, "chip selects released");
    chk(csPullupEn, 4'h1, "hold pullups");
    chk({strobePullupEn, readStrobeN, writeLowStrobeN}, 4'h7, "strobes in hold");
    @(posedge clk);
    wantHold <= 1'h0;
    busRequestInt <= 1'h0;
    n = 0;
    while (holdMode !== 1'h0 && n < 10) begin
      n++;
      @(negedge clk);
    end
    chk(4'(n < 10), 4'h1, "hold left");
    chk({holdAcknowledgeOutput, busRequestOutput}, 4'h3, "arbitration idle");
    chk(strobePullupEn, 4'h0, "strobe pullup off after hold");
  endtask : tskHold

  task automatic tskNmi();
    int n;
    @(posedge clk);
    nmiPinN <= 1'h0;
    n = 0;
    @(negedge clk);
    while (nmiTrap !== 1'h1 && n < 10) begin
      n++;
      @(negedge clk);
    end
    chk(4'(n >= 3 && n <= 5), 4'h1, "trap delay");
    @(negedge clk);
    chk({nmiTrap, powerDownValid}, 4'h1, "single trap pulse");
  endtask : tskNmi

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (3000) @(posedge clk);
    badCount++;
    stopTest();
  end

  initial begin
    {rstn, odWrite, arbitrationEnableBit, busRequestInt, cycleStart, cycleRead} = '0;
    {cycleWrite, byteHigh, byteLow, peripheralVisibilityBit, readyCtlEn, readyAsyncMode} = '0;
    {wantHold, bootConfigPort, csSelect, gpioOut, gpioOe, odWriteData, waitStates} = '0;
    {readyWait, busActiveBits, externalAccessSelect} = '0;
    nmiPinN = 1'h1;
    cycleKind = EBPC_ACC_INTERNAL;
    writeMode = EBPC_WR_GENERAL;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    tskStraps();
    tskPins();
    tskStrobes();
    tskReady();
    tskHold();
    tskNmi();
    stopTest();
  end
endmodule : ebpc_pin_control_tb
`default_nettype wire
